// [src/pado_pkg.sv]
package pado_pkg;
   // =========================================
   // Widths
   localparam int STAGE_COUNT = 9;
   localparam int STAGE_BITS = 2;
   localparam int WORD_BITS = 10;
   localparam int RAW_BITS = STAGE_COUNT * STAGE_BITS;
   // =========================================
   // Timing counts, in sample-clock cycles
   localparam int LATENCY_CYCLES = 7;
   localparam int INIT_CYCLES = 20;
   // =========================================
   // Clock figures
   localparam int CLK_PERIOD_NS = 20;
   localparam int MIN_RATE_KSPS = 1000;
   localparam int MAX_PERIOD_NS = 1000000 / MIN_RATE_KSPS;
   // =========================================
   // Output format codes
   typedef enum logic {
      PADO_FMT_OFFSET,
      PADO_FMT_TWOS
   } pado_format_type;
   localparam logic FMT_SELECT_RESET = 1'b0;
endpackage

// [src/pado_link_if.sv]
`timescale 1ns/10ps
`default_nettype none
// Parallel output bus between converter and capturing logic
interface pado_link_if;
   logic [pado_pkg::WORD_BITS-1:0] dataOut;
   logic [pado_pkg::WORD_BITS-1:0] dataOe;
   logic outputEnable_b;
   logic outputFormatSelect;
   logic dataValid;
   modport converter (
      output dataOut,
      output dataOe,
      output dataValid,
      input outputEnable_b,
      input outputFormatSelect
   );
   modport capture (
      input dataOut,
      input dataOe,
      input dataValid,
      output outputEnable_b,
      output outputFormatSelect
   );
endinterface
`default_nettype wire

// [src/pado_stage_delay.sv]
`timescale 1ns/10ps
`default_nettype none
// Shift register delaying one stage's two-bit decision by DEPTH cycles
module pado_stage_delay #(
   parameter int WIDTH = 2,
   parameter int DEPTH = 1
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Data
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [DEPTH:0][WIDTH-1:0] pipe_r;
   logic [DEPTH:0][WIDTH-1:0] pipe_nxt;

   // =========================================
   // Delay line
   // Next values: shift by one each edge
   always_comb begin
      pipe_nxt = pipe_r;
      pipe_nxt[0] = din;
      for (int i = 1; i <= DEPTH; i++) begin
         pipe_nxt[i] = pipe_r[i-1];
      end
   end

   // Register only
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pipe_r <= '0;
      end else begin
         pipe_r <= pipe_nxt;
      end
   end

   // A zero-depth stage must never index below the pipe, so split here
   if (DEPTH == 0) begin : g_wire
      assign dout = din;
   end else begin : g_pipe
      assign dout = pipe_r[DEPTH-1];
   end
endmodule
`default_nettype wire

// [src/pado_converter.sv]
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Word appears eighth clock after sampling.
// - One new word every cycle afterwards.
// - Output passes two-stage latch to pins.
// - Format high inverts MSB: two's complement.
// - Enable_b high tristates, low drives outputs.
// - First twenty cycles give invalid data.
// - Clock source keeps rate above minimum.
// - Clock source keeps near-even duty, low jitter.
// - Two non-overlapping phases, sample then hold.
// - Adjacent stages run in opposite phase.
// - Delay line aligns nine two-bit stage results.
// - Supplementary bits correct stage errors on merge.
// - Sample taken on sample clock falling edge.
module pado_converter (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Stage decisions from the analog core, stage 0 first
   input wire logic [pado_pkg::RAW_BITS-1:0] stageCode,
   // Output bus
   pado_link_if.converter link,
   // Internal phase clocks, for the analog switches
   output logic phaseSample,
   output logic phaseHold,
   output logic [pado_pkg::STAGE_COUNT-1:0] stagePhase
);
   localparam int N = pado_pkg::STAGE_COUNT;
   localparam int B = pado_pkg::STAGE_BITS;
   localparam int W = pado_pkg::WORD_BITS;
   // Stage k decides k half-cycles after sampling, i.e. at full cycle k/2;
   // aligning adds the remaining depth so all meet at the last stage.
   localparam int ALIGN_TOP = (N - 1) / 2;
   // Cycles left after correction and the two output latches
   // Alignment four, correction one, padding one, latches two: eight edges in all
   localparam int TAIL = pado_pkg::LATENCY_CYCLES - ALIGN_TOP - 3;
   localparam int VALID_CYCLES = pado_pkg::INIT_CYCLES + pado_pkg::LATENCY_CYCLES;

   logic [N-1:0][B-1:0] aligned;
   logic [W-1:0] merged;
   logic [W-1:0] corr_r, corr_nxt;
   logic [TAIL:0][W-1:0] tail_r, tail_nxt;
   logic [W-1:0] latchA_r, latchA_nxt;
   logic [W-1:0] latchB_r, latchB_nxt;
   logic fmtSync1_r, fmtSync2_r;
   logic fmtSync1_nxt, fmtSync2_nxt;
   logic oeSync1_r, oeSync2_r;
   logic oeSync1_nxt, oeSync2_nxt;
   logic [5:0] warm_r, warm_nxt;
   logic valid_r, valid_nxt;
   logic phaseHigh_r;
   logic phaseHigh_nxt;
   logic phaseLow_r;
   logic phaseLow_nxt;

   // =========================================
   // Phase generation
   // Sample phase on high half; falling edge ends it and takes the sample
   // Enables set once and stay set while the clock runs
   always_comb begin
      phaseHigh_nxt = 1'b1;
      phaseLow_nxt = 1'b1;
   end
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         phaseHigh_r <= 1'b0;
      end else begin
         phaseHigh_r <= phaseHigh_nxt;
      end
   end
   always_ff @(negedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         phaseLow_r <= 1'b0;
      end else begin
         phaseLow_r <= phaseLow_nxt;
      end
   end
   // Gating with both enables keeps the phases apart through reset
   // Gating is safe: these feed analog switches, never flops
   assign phaseSample = clk_sys & phaseHigh_r & phaseLow_r;
   assign phaseHold = ~clk_sys & phaseHigh_r & phaseLow_r;
   // Even stages on sample phase, odd stages on hold phase
   always_comb begin
      for (int k = 0; k < N; k++) begin
         stagePhase[k] = (k % 2 == 0) ? phaseSample : phaseHold;
      end
   end

   // =========================================
   // Stage alignment
   // Each stage delayed so the nine decisions form one eighteen-bit word
   // The last stage needs no delay and passes straight through
   for (genvar k = 0; k < N; k++) begin : g_align
      pado_stage_delay #(
         .WIDTH(B),
         .DEPTH(ALIGN_TOP - k / 2)
      ) u_delay (
         .clk_sys(clk_sys),
         .rst_b(rst_b),
         .din(stageCode[k*B +: B]),
         .dout(aligned[k])
      );
   end

   // =========================================
   // Error correction
   // Overlap-add: each stage's supplementary bit carries into the
   // bit above, so a decision one step off is absorbed downstream.
   always_comb begin
      logic [W:0] acc;
      acc = '0;
      for (int k = 0; k < N; k++) begin
         acc = acc + ((W+1)'(aligned[k]) << (N - 1 - k));
      end
      // Overflow saturates to full scale rather than wrapping
      // Limitation: a stuck stage saturates silently, nothing flags it
      merged = acc[W] ? {W{1'b1}} : acc[W-1:0];
   end

   // =========================================
   // Output pipeline
   // Correction register, padding to fixed latency, then two latches
   // Second latch holds each word a full cycle for the capturing side
   always_comb begin
      corr_nxt = merged;
      tail_nxt = tail_r;
      tail_nxt[0] = corr_r;
      for (int i = 1; i <= TAIL; i++) begin
         tail_nxt[i] = tail_r[i-1];
      end
      latchA_nxt = tail_r[TAIL];
      // Format applied at the second latch; MSB flip gives two's complement
      latchB_nxt = latchA_r;
      if (fmtSync2_r == pado_pkg::PADO_FMT_TWOS) begin
         latchB_nxt[W-1] = ~latchA_r[W-1];
      end
   end
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         corr_r <= '0;
         tail_r <= '0;
         latchA_r <= '0;
         latchB_r <= '0;
      end else begin
         corr_r <= corr_nxt;
         tail_r <= tail_nxt;
         latchA_r <= latchA_nxt;
         latchB_r <= latchB_nxt;
      end
   end

   // =========================================
   // Pin synchronisers
   // Format and enable pins come from outside; two flops each
   // Trade-off: a format change lands a few edges after the pin moves
   always_comb begin
      fmtSync1_nxt = link.outputFormatSelect;
      fmtSync2_nxt = fmtSync1_r;
      oeSync1_nxt = link.outputEnable_b;
      oeSync2_nxt = oeSync1_r;
   end
   // Reset leaves the outputs floating so a shared bus sees no fight
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         fmtSync1_r <= pado_pkg::FMT_SELECT_RESET;
         fmtSync2_r <= pado_pkg::FMT_SELECT_RESET;
         oeSync1_r <= 1'b1;
         oeSync2_r <= 1'b1;
      end else begin
         fmtSync1_r <= fmtSync1_nxt;
         fmtSync2_r <= fmtSync2_nxt;
         oeSync1_r <= oeSync1_nxt;
         oeSync2_r <= oeSync2_nxt;
      end
   end

   // =========================================
   // Power-up warm-up and valid flag
   // Counter saturates; pipeline holds junk until it does
   // One count covers both init and latency, so no second timer
   // Valid is registered so it moves on the same edge as the word
   always_comb begin
      warm_nxt = warm_r;
      if (warm_r != 6'(VALID_CYCLES)) begin
         warm_nxt = warm_r + 6'h01;
      end
      valid_nxt = (warm_nxt == 6'(VALID_CYCLES));
   end
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         warm_r <= 6'h00;
         valid_r <= 1'b0;
      end else begin
         warm_r <= warm_nxt;
         valid_r <= valid_nxt;
      end
   end

   // =========================================
   // Pin drive
   // Enable lags the pin by the sync flops; the word stream never stops
   assign link.dataOut = latchB_r;
   assign link.dataOe = {W{~oeSync2_r}};
   assign link.dataValid = valid_r;
endmodule
`default_nettype wire

// [src/pado_capture.sv]
`timescale 1ns/10ps
`default_nettype none
// Capturing logic: drives the control pins and registers valid words
module pado_capture (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // User controls
   input wire logic wantTwos,
   input wire logic busEnable,
   // Captured word
   output logic [pado_pkg::WORD_BITS-1:0] word,
   output logic wordValid,
   // Output bus
   pado_link_if.capture link
);
   logic [pado_pkg::WORD_BITS-1:0] word_r, word_nxt;
   logic wordValid_r, wordValid_nxt;

   // =========================================
   // Control pins
   assign link.outputFormatSelect = wantTwos;
   assign link.outputEnable_b = ~busEnable;

   // =========================================
   // Capture; words before the valid flag are discarded
   always_comb begin
      word_nxt = word_r;
      wordValid_nxt = 1'b0;
      if (link.dataValid && (&link.dataOe)) begin
         word_nxt = link.dataOut;
         wordValid_nxt = 1'b1;
      end
   end
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         word_r <= '0;
         wordValid_r <= 1'b0;
      end else begin
         word_r <= word_nxt;
         wordValid_r <= wordValid_nxt;
      end
   end
   assign word = word_r;
   assign wordValid = wordValid_r;
endmodule
`default_nettype wire

// [test/pado_sva.sv]
`timescale 1ns/10ps
`default_nettype none
// ==========
// Link checker
module pado_sva (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Link signals
   input wire logic [pado_pkg::WORD_BITS-1:0] dataOut,
   input wire logic [pado_pkg::WORD_BITS-1:0] dataOe,
   input wire logic outputEnable_b,
   input wire logic outputFormatSelect,
   input wire logic dataValid
);
   logic [5:0] cnt_r;
   logic [5:0] cnt_nxt;
   // Edges since release; saturates so it never wraps
   always_comb begin
      cnt_nxt = (cnt_r == 6'h3f) ? cnt_r : cnt_r + 6'h01;
   end
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cnt_r <= 6'h00;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   // ==========
   // Assertions
   AST_OE_OFF: assert property (outputEnable_b [*4] |-> dataOe == '0)
      else $error("outputs drive while disabled");
   AST_OE_ON: assert property (!outputEnable_b [*4] |-> dataOe == '1)
      else $error("outputs float while enabled");
   AST_OE_LAG: assert property (outputEnable_b [*4] ##1 !outputEnable_b |-> (dataOe == '0) [*2] ##1 dataOe == '1)
      else $error("enable reached outputs too early");
   AST_OE_UNIFORM: assert property (dataOe == '0 || dataOe == '1)
      else $error("output enables disagree");
   AST_VALID_EARLY: assert property (cnt_r < pado_pkg::INIT_CYCLES |-> !dataValid)
      else $error("valid during initialisation");
   AST_VALID_HOLD: assert property (cnt_r < pado_pkg::INIT_CYCLES + pado_pkg::LATENCY_CYCLES |-> !dataValid)
      else $error("valid before latency elapsed");
   AST_VALID_SET: assert property (cnt_r >= pado_pkg::INIT_CYCLES + pado_pkg::LATENCY_CYCLES |-> dataValid)
      else $error("valid missing after latency");
   AST_VALID_STAYS: assert property (dataValid |=> dataValid)
      else $error("valid dropped mid stream");
   // Main scenarios
   cover property ($rose(dataValid));
   cover property (dataValid && outputFormatSelect && dataOut == 10'h000);
   cover property (dataValid && $rose(outputEnable_b));
endmodule
`default_nettype wire

// [test/pipeline_adc_output_logic_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module pipeline_adc_output_logic_tb;
   typedef struct {logic [17:0] c; logic t; logic [9:0] w;} pado_row_type;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic [pado_pkg::RAW_BITS-1:0] stageCode = '0;
   logic wantTwos = 1'b0;
   logic busEnable = 1'b1;
   logic [pado_pkg::WORD_BITS-1:0] word;
   logic wordValid;
   logic phaseSample;
   logic phaseHold;
   logic [pado_pkg::STAGE_COUNT-1:0] stagePhase;
   logic [17:0] hist [$];
   int n_errors = 0;
   int checks = 0;
   // Ordinary cases: code, format, expected word
   pado_row_type rows [6] = '{'{18'h00000, 1'b0, 10'h000}, '{18'h00000, 1'b1, 10'h200},
      '{18'h00002, 1'b0, 10'h200}, '{18'h10000, 1'b0, 10'h001},
      '{18'h3ffff, 1'b1, 10'h1ff}, '{18'h00005, 1'b1, 10'h380}};
   // ==========
   // Two ends joined by the link
   pado_link_if link ();
   pado_converter pado_converter_i (.clk_sys(clk_sys), .rst_b(rst_b), .stageCode(stageCode), .link(link),
      .phaseSample(phaseSample), .phaseHold(phaseHold), .stagePhase(stagePhase));
   pado_capture pado_capture_i (.clk_sys(clk_sys), .rst_b(rst_b), .wantTwos(wantTwos),
      .busEnable(busEnable), .word(word), .wordValid(wordValid), .link(link));
   pado_sva pado_sva_i (.clk_sys(clk_sys), .rst_b(rst_b), .dataOut(link.dataOut), .dataOe(link.dataOe),
      .outputEnable_b(link.outputEnable_b), .outputFormatSelect(link.outputFormatSelect),
      .dataValid(link.dataValid));
   // ==========
   // Helpers
   function automatic logic [9:0] expw(input logic [17:0] c, input logic t);
      int s = 0;
      for (int k = 0; k < 9; k++) begin
         s += int'(c[2*k +: 2]) << (8 - k);
      end
      // Overlap-add can exceed full scale
      if (s > 1023) begin
         s = 1023;
      end
      return 10'(s) ^ {t, 9'h000};
   endfunction
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask
   // Inputs move 1 ns after the edge, clear of sampling
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic close_out();
      if (n_errors == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Free-running sample clock, even duty, far above the minimum rate
   initial begin
      forever #(pado_pkg::CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;
   end
   // ==========
   // Main sequence
   initial begin
      int n;
      logic [5:0] v;
      logic [17:0] sc;
      step(1);
      chk("dataOut", link.dataOut, 0);
      chk("dataOe", link.dataOe, 0);
      chk("dataValid", link.dataValid, 0);
      chk("wordValid", wordValid, 0);
      chk("phaseSample", phaseSample, 0);
      step(3);
      rst_b = 1'b1;
      n = 0;
      while (link.dataValid !== 1'b1 && n < 40) begin
         step(1);
         n++;
      end
      chk("validEdges", n, 27);
      if (n >= 40) begin
         close_out();
      end
      // Phases while clock high, then low
      #4;
      chk("phasesHigh", {phaseSample, phaseHold, stagePhase}, 11'h555);
      #10;
      chk("phasesLow", {phaseSample, phaseHold, stagePhase}, 11'h2aa);
      step(1);
      foreach (rows[i]) begin
         wantTwos = rows[i].t;
         stageCode = rows[i].c;
         step(12);
         chk("dataOut", link.dataOut, rows[i].w);
         chk("word", word, rows[i].w);
      end
      // Distinct words back to back; latency shows as a shift
      wantTwos = 1'b0;
      for (int j = 0; j < 24; j++) begin
         if (j >= 8) begin
            chk("streamOut", link.dataOut, expw(hist[j-8], 1'b0));
         end
         if (j >= 9) begin
            chk("streamWord", {wordValid, word}, {1'b1, expw(hist[j-9], 1'b0)});
         end
         // Stage k of a sample reaches the core k/2 cycles after stage 0
         v = 6'(j);
         hist.push_back({v[1:0], 4'h0, v[3:2], 4'h0, v[5:4], 4'h0});
         for (int k = 0; k < 9; k++) begin
            sc[2*k +: 2] = (j >= k / 2) ? hist[j - k / 2][2*k +: 2] : 2'h0;
         end
         stageCode = sc;
         step(1);
      end
      chk("streamValid", link.dataValid, 1);
      busEnable = 1'b0;
      step(6);
      chk("dataOeOff", link.dataOe, 0);
      chk("wordDropped", wordValid, 0);
      busEnable = 1'b1;
      step(6);
      chk("dataOeOn", link.dataOe, 10'h3ff);
      close_out();
   end
endmodule
`default_nettype wire
